// File: verilog/csd_pkg.sv
// constants shared by the chopped sinc3 decimator files
package csd_pkg;
    // clock and modulator timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MOD_RATE_HZ = 32768;
    localparam int MOD_DIV = CLK_HZ / MOD_RATE_HZ;
    localparam int DEC_MULT = 8;
    localparam int WINDOWS = 3;
    localparam int ACC_W = 34;
    localparam int RATIO_W = 11;
    // decimation word limits
    localparam logic [7:0] DEC_MIN = 8'h0D;
    localparam logic [7:0] DEC_MIN_NC = 8'h03;
    localparam logic [7:0] DEC_RST = 8'h45;
    // register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_CHAN = 8'h04;
    localparam logic [7:0] A_DECIM = 8'h08;
    localparam logic [7:0] A_DATA = 8'h0C;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_IRQ = 8'h14;
    localparam logic [7:0] A_MASK = 8'h18;
    // field positions
    localparam int MODE_CHOPDIS = 0;
    localparam int MODE_PSEUDO = 1;
    localparam int CHAN_LSB = 0;
    localparam int GAIN_LSB = 4;
    localparam logic [3:0] CHAN_MAX_PSEUDO = 4'h9;
    localparam logic [3:0] CHAN_MAX_DIFF = 4'h4;
    localparam int IRQ_READY = 0;
    localparam int IRQ_OVR = 1;
    localparam int IRQ_W = 2;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : csd_pkg

// File: verilog/csd_sinc3.sv
// cubic sinc decimator fed by the one-bit modulator stream
`timescale 1ns/10ps
module csd_sinc3 (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // modulator stream
    input wire logic tick,
    input wire logic mod_bit,
    // control
    input wire logic flush,
    input wire logic [csd_pkg::RATIO_W-1:0] ratio,
    // decimated output
    output logic signed [csd_pkg::ACC_W-1:0] out_data,
    output logic out_valid
);
    import csd_pkg::*;

    logic signed [ACC_W-1:0] i1_q, i2_q, i3_q, d1_q, d2_q, d3_q;
    logic signed [ACC_W-1:0] x, c1, c2, c3;
    logic [RATIO_W-1:0] cnt_q;
    logic dump;

    assign x = mod_bit ? ACC_W'(1) : -ACC_W'(1);
    assign dump = tick && (cnt_q == ratio - RATIO_W'(1));
    assign c1 = i3_q - d1_q;
    assign c2 = c1 - d2_q;
    assign c3 = c2 - d3_q;

    // integrators take the raw bit, no stage in between
    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            i1_q <= '0;
            i2_q <= '0;
            i3_q <= '0;
        end else if (tick) begin
            i1_q <= i1_q + x;
            i2_q <= i2_q + i1_q;
            i3_q <= i3_q + i2_q;
        end
    end

    // decimation by eight times the word
    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            cnt_q <= '0;
        end else if (dump) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + RATIO_W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || flush) begin
            d1_q <= '0;
            d2_q <= '0;
            d3_q <= '0;
            out_data <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= dump;
            if (dump) begin
                d1_q <= i3_q;
                d2_q <= c1;
                d3_q <= c2;
                out_data <= c3;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_valid_spacing: assert property (out_valid |=> !out_valid [*8])
        else $error("filter outputs closer than the decimation ratio");
    a_flush_clears: assert property (flush |=> (i1_q == 0 && cnt_q == 0))
        else $error("flush left the integrators loaded");
endmodule // csd_sinc3

// File: verilog/csd_top.sv
// chopped sinc3 decimator with averaging and register slave
`timescale 1ns/10ps
module csd_top #(
    parameter int RESULT_W = 24,
    parameter int TICK_DIV = csd_pkg::MOD_DIV
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // modulator stream
    input wire logic mod_bit,
    // front-end control and status
    output logic chop_q,
    output logic [2:0] gain_q,
    output logic [3:0] chan_q,
    output logic pseudo_q,
    output logic rdy_n_q,
    output logic irq_q,
    // axi4-lite write
    input wire logic [csd_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [csd_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import csd_pkg::*;

    if (!(RESULT_W == 16 || RESULT_W == 24)) begin : g_bad_width
        $error("RESULT_W must be 16 or 24");
    end
    if (TICK_DIV < 9 || TICK_DIV > 2048) begin : g_bad_div
        $error("modulator tick divider out of range");
    end

    typedef enum logic [0:0] {ST_FLUSH, ST_CONVERT} csd_state_t;

    function automatic logic csd_mapped(input logic [ADDR_W-1:0] a);
        csd_mapped = (a == A_MODE) || (a == A_CHAN) || (a == A_DECIM) ||
                     (a == A_DATA) || (a == A_STAT) || (a == A_IRQ) ||
                     (a == A_MASK);
    endfunction

    csd_state_t st_q;
    logic [10:0] div_q;
    logic tick_q;
    logic chop_dis_q;
    logic [7:0] decim_q;
    logic [RESULT_W-1:0] data_q;
    logic signed [ACC_W-1:0] prev_q;
    logic have_prev_q, unread_q;
    logic [1:0] win_q;
    logic [IRQ_W-1:0] irq_st_q, irq_mask_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q, aw_full_q, w_full_q;
    logic signed [ACC_W-1:0] f_data, fo;
    logic signed [ACC_W:0] sum_w;
    logic f_valid, conv, res_wr, wr_do, prog_chg, data_rd, irq_rd;
    logic [7:0] wd;
    logic [3:0] new_chan;

    ////////////////////////////////////////////////////////////////////////
    // modulator-rate enable
    always_ff @(posedge clock) begin
        if (!rstn || div_q == 11'(TICK_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 11'h001;
        end
    end

    always_ff @(posedge clock) begin
        tick_q <= rstn && (div_q == 11'(TICK_DIV - 1));
    end

    csd_sinc3 u_sinc3 (
        .clock(clock),
        .rstn(rstn),
        .tick(tick_q),
        .mod_bit(mod_bit),
        .flush(st_q == ST_FLUSH),
        .ratio(RATIO_W'(decim_q) * RATIO_W'(DEC_MULT)),
        .out_data(f_data),
        .out_valid(f_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus write path
    assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wd = wdata_q[7:0];
    assign prog_chg = wr_do && wstrb0_q &&
        (awaddr_q == A_MODE || awaddr_q == A_CHAN || awaddr_q == A_DECIM);
    assign data_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == A_DATA;
    assign irq_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == A_IRQ;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
                w_full_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= csd_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // mode and front-end configuration
    always_ff @(posedge clock) begin
        if (!rstn) begin
            chop_dis_q <= 1'b0;
            pseudo_q <= 1'b0;
        end else if (wr_do && wstrb0_q && awaddr_q == A_MODE) begin
            chop_dis_q <= wd[MODE_CHOPDIS];
            pseudo_q <= wd[MODE_PSEUDO];
        end
    end

    assign new_chan = wd[CHAN_LSB +: 4];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            chan_q <= '0;
            gain_q <= '0;
        end else if (wr_do && wstrb0_q && awaddr_q == A_CHAN) begin
            gain_q <= wd[GAIN_LSB +: 3];
            if (new_chan <= (pseudo_q ? CHAN_MAX_PSEUDO : CHAN_MAX_DIFF)) begin
                chan_q <= new_chan;
            end
        end
    end

    // word clamped to the chop-mode floor, or to the no-chop floor with chop disabled
    always_ff @(posedge clock) begin
        if (!rstn) begin
            decim_q <= DEC_RST;
        end else if (wr_do && wstrb0_q && awaddr_q == A_DECIM) begin
            if (!chop_dis_q && wd < DEC_MIN) begin
                decim_q <= DEC_MIN;
            end else if (wd < DEC_MIN_NC) begin
                decim_q <= DEC_MIN_NC;
            end else begin
                decim_q <= wd;
            end
        end else if (!chop_dis_q && decim_q < DEC_MIN) begin
            decim_q <= DEC_MIN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencing: three filter windows per chop phase
    assign conv = (st_q == ST_CONVERT) && f_valid && win_q == 2'(WINDOWS - 1);
    assign fo = (chop_q && !chop_dis_q) ? -f_data : f_data;
    assign sum_w = {prev_q[ACC_W-1], prev_q} + {fo[ACC_W-1], fo};
    assign res_wr = conv && (chop_dis_q || have_prev_q);

    always_ff @(posedge clock) begin
        if (!rstn || prog_chg) begin
            st_q <= ST_FLUSH;
            win_q <= '0;
        end else begin
            case (st_q)
                ST_FLUSH: begin
                    st_q <= ST_CONVERT;
                    win_q <= '0;
                end
                ST_CONVERT: begin
                    if (conv) begin
                        st_q <= ST_FLUSH;
                    end else if (f_valid) begin
                        win_q <= win_q + 2'h1;
                    end
                end
                default: st_q <= ST_FLUSH;
            endcase
        end
    end

    // chop polarity flips once per conversion, every third filter output
    always_ff @(posedge clock) begin
        if (!rstn || prog_chg || chop_dis_q) begin
            chop_q <= 1'b0;
        end else if (conv) begin
            chop_q <= !chop_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || prog_chg) begin
            prev_q <= '0;
            have_prev_q <= 1'b0;
        end else if (conv) begin
            prev_q <= fo;
            have_prev_q <= !chop_dis_q;
        end
    end

    // running average of two, nulls from sinc3 times sinc2
    always_ff @(posedge clock) begin
        if (!rstn) begin
            data_q <= '0;
        end else if (res_wr && chop_dis_q) begin
            data_q <= f_data[ACC_W-1 -: RESULT_W];
        end else if (res_wr) begin
            data_q <= sum_w[ACC_W -: RESULT_W];
        end
    end

    // ready goes high one window ahead of an update
    always_ff @(posedge clock) begin
        if (!rstn || prog_chg) begin
            rdy_n_q <= 1'b1;
        end else if (res_wr) begin
            rdy_n_q <= 1'b0;
        end else if (data_rd ||
                     (st_q == ST_CONVERT && f_valid && win_q == 2'h1)) begin
            rdy_n_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || prog_chg) begin
            unread_q <= 1'b0;
        end else if (res_wr) begin
            unread_q <= 1'b1;
        end else if (data_rd) begin
            unread_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, cleared by read, set wins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_rd ? '0 : irq_st_q) |
                        {res_wr && unread_q, res_wr};
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_mask_q <= '0;
        end else if (wr_do && wstrb0_q && awaddr_q == A_MASK) begin
            irq_mask_q <= wd[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock) begin
        irq_q <= rstn && |(irq_st_q & irq_mask_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // bus read path
    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= csd_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                A_MODE: s_axi_rdata <= 32'({pseudo_q, chop_dis_q});
                A_CHAN: s_axi_rdata <= 32'({gain_q, chan_q});
                A_DECIM: s_axi_rdata <= 32'(decim_q);
                A_DATA: s_axi_rdata <= 32'(signed'(data_q));
                A_STAT: s_axi_rdata <= 32'({have_prev_q, chop_q, !rdy_n_q});
                A_IRQ: s_axi_rdata <= 32'(irq_st_q);
                A_MASK: s_axi_rdata <= 32'(irq_mask_q);
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence s_update;
        res_wr ##1 !rdy_n_q;
    endsequence

    a_rdy_on_write: assert property (res_wr && !prog_chg
        |-> s_update)
        else $error("ready not low after a result update");
    a_rdy_on_read: assert property (data_rd && !res_wr |=> rdy_n_q)
        else $error("ready not high after data read");
    a_word_floor: assert property (!chop_dis_q |-> ##1 decim_q >= DEC_MIN)
        else $error("decimation word below chop floor");
    a_word_reset: assert property ($past(!rstn) |-> decim_q == DEC_RST)
        else $error("decimation word reset value wrong");
    a_chop_toggle: assert property (conv && !chop_dis_q && !prog_chg
        |=> chop_q != $past(chop_q))
        else $error("chop polarity did not flip");
    a_first_no_avg: assert property (conv && !have_prev_q && !chop_dis_q
        && !prog_chg |-> !res_wr ##1 (have_prev_q && rdy_n_q))
        else $error("single filter output written without averaging");
    a_prog_holdoff: assert property (prog_chg |=> rdy_n_q [*8])
        else $error("ready asserted too soon after reprogramming");
    a_flush_cycle: assert property (conv && !prog_chg
        |=> st_q == ST_FLUSH ##1 st_q == ST_CONVERT)
        else $error("filter not flushed between chop phases");
    a_tick_period: assert property (tick_q |=> !tick_q [*8])
        else $error("modulator enable too frequent");
endmodule // csd_top

// File: testbench/csd_mod_model.sv
// modulator bit stream model for the decimator bench
`timescale 1ns/10ps
module csd_mod_model (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // stream
    input wire logic [7:0] density,
    input wire logic chop,
    output logic mod_bit
);
    logic [8:0] acc_q;
    // first order loop: ones density is density/256
    always_ff @(posedge clock) begin
        if (!rstn) begin
            acc_q <= 9'h000;
        end else begin
            acc_q <= {1'b0, acc_q[7:0]} + {1'b0, density};
        end
    end
    // front end reverses its inputs while chop is high
    assign mod_bit = acc_q[8] ^ chop;
endmodule // csd_mod_model

// File: testbench/csd_top_tb_top.sv
// register and settling bench for the chopped sinc3 decimator
`timescale 1ns/10ps
module csd_top_tb_top;
    import csd_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic mod_bit, chop_q, pseudo_q, rdy_n_q, irq_q;
    logic [7:0] density = 8'h80;
    logic [2:0] gain_q;
    logic [3:0] chan_q;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int num_errors = 0;
    int n_tests = 0;
    // fast modulator tick so whole conversions fit the run
    localparam int BENCH_DIV = 9;
    always #10 clock = ~clock;
    csd_mod_model model (.clock(clock), .rstn(rstn), .density(density),
        .chop(chop_q), .mod_bit(mod_bit));
    csd_top #(.RESULT_W(24), .TICK_DIV(BENCH_DIV)) dut (.clock(clock),
        .rstn(rstn),
        .mod_bit(mod_bit), .chop_q(chop_q), .gain_q(gain_q),
        .chan_q(chan_q), .pseudo_q(pseudo_q), .rdy_n_q(rdy_n_q),
        .irq_q(irq_q), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hang();
        num_errors++;
        $display("wrong value bus wait expected answer seen none");
        end_of_test();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [1:0] r);
        int n;
        logic ad, wd;
        n = 0;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (!ad && awready) begin
                ad = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
            if (n > 100) hang();
        end while (!(ad && wd));
        do begin
            @(posedge clock);
            n++;
            if (n > 200) hang();
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (n > 100) hang();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge clock);
            n++;
            if (n > 200) hang();
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask
    // waits for ready to be high, then low; counts edges and chop rises
    task automatic wait_rdy(output int n, output int rises);
        logic hi, c;
        n = 0;
        rises = 0;
        hi = rdy_n_q;
        c = chop_q;
        do begin
            @(posedge clock);
            n++;
            if (chop_q === 1'b1 && c === 1'b0) rises++;
            c = chop_q;
            if (rdy_n_q === 1'b1) hi = 1'b1;
            if (n > 8000) begin
                num_errors++;
                $display("wrong value rdy_n_q expected low seen high");
                end_of_test();
            end
        end while (!(hi && rdy_n_q === 1'b0));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hF, r);
        chk("write response", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
        chk(nm, e, d);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk("decimation_word", A_DECIM, {24'h0, DEC_RST});
        rd_chk("mode", A_MODE, 32'h0);
        chk("chop_q", 32'h0, {31'h0, chop_q});
        chk("rdy_n_q", 32'h1, {31'h0, rdy_n_q});
        chk("irq_q", 32'h0, {31'h0, irq_q});
    endtask
    task automatic t_decim();
        logic [7:0] wv[6] = '{8'h0C, 8'h0D, 8'h44, 8'h52, 8'hFF, 8'h45};
        logic [7:0] ev[6] = '{8'h0D, 8'h0D, 8'h44, 8'h52, 8'hFF, 8'h45};
        logic [1:0] r;
        foreach (wv[i]) begin
            wr(A_DECIM, {24'h0, wv[i]});
            rd_chk("decimation_word", A_DECIM, {24'h0, ev[i]});
            chk("rdy_n_q", 32'h1, {31'h0, rdy_n_q});
        end
        axi_wr(A_DECIM, 32'h20, 4'h0, r);
        chk("masked write", {30'h0, RESP_OKAY}, {30'h0, r});
        rd_chk("decimation_word", A_DECIM, 32'h45);
    endtask
    task automatic t_front();
        wr(A_MODE, 32'h2);
        chk("pseudo_q", 32'h1, {31'h0, pseudo_q});
        wr(A_CHAN, 32'h79);
        chk("chan_q", 32'h9, {28'h0, chan_q});
        chk("gain_q", 32'h7, {29'h0, gain_q});
        wr(A_MODE, 32'h0);
        wr(A_CHAN, 32'h05);
        chk("chan_q", 32'h9, {28'h0, chan_q});
        chk("gain_q", 32'h0, {29'h0, gain_q});
        wr(A_CHAN, 32'h34);
        chk("chan_q", 32'h4, {28'h0, chan_q});
        chk("gain_q", 32'h3, {29'h0, gain_q});
        wr(A_MODE, 32'h1);
        wr(A_DECIM, 32'h03);
        rd_chk("decimation_word", A_DECIM, 32'h03);
        chk("chop_q", 32'h0, {31'h0, chop_q});
        wr(A_MODE, 32'h0);
        wr(A_DECIM, 32'h45);
    endtask
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(8'h1C, 32'hFF, 4'hF, r);
        chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_rd(8'h1C, d, r);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped data", 32'h0, d);
    endtask
    task automatic t_irq();
        wr(A_MASK, 32'h3);
        rd_chk("mask", A_MASK, 32'h3);
        rd_chk("irq status", A_IRQ, 32'h0);
        chk("irq_q", 32'h0, {31'h0, irq_q});
        rd_chk("status", A_STAT, 32'h0);
        wr(A_MASK, 32'h0);
    endtask
    task automatic t_settle();
        int n, rises, n3, per;
        logic [31:0] ev;
        n3 = (DEC_MULT * int'(DEC_MIN)) ** 3;
        per = WINDOWS * DEC_MULT * int'(DEC_MIN) * BENCH_DIV;
        // zero density: minus ones, plus ones while chop is high; full scale sinc3 gain
        ev = 32'((-n3) >>> (ACC_W - 24));
        density <= 8'h00;
        wr(A_MASK, 32'h3);
        wr(A_DECIM, {24'h0, DEC_MIN});
        wait_rdy(n, rises);
        chk("settle window", 32'h1, {31'h0, n >= 2 * per - BENCH_DIV &&
            n <= 2 * per + BENCH_DIV});
        chk("chop rises", 32'h1, 32'(rises));
        rd_chk("data", A_DATA, ev);
        chk("rdy_n_q", 32'h1, {31'h0, rdy_n_q});
        chk("irq_q", 32'h1, {31'h0, irq_q});
        rd_chk("irq status", A_IRQ, 32'h1);
        chk("irq_q", 32'h0, {31'h0, irq_q});
        wait_rdy(n, rises);
        wait_rdy(n, rises);
        chk("conversion period", 32'(per), 32'(n));
        rd_chk("irq status", A_IRQ, 32'h3);
        rd_chk("data", A_DATA, ev);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_decim();
        t_front();
        t_unmapped();
        t_irq();
        t_settle();
        end_of_test();
    end
endmodule // csd_top_tb_top
